/* File: verilog/tcm_pkg.sv */
// Package for the timer/counter with capture and match
package tcm_pkg;
	localparam int unsigned TCM_CH = 4;
	// Register byte addresses
	localparam logic [7:0] TCM_CTRL_ADDR = 8'h00;
	localparam logic [7:0] TCM_COUNT_ADDR = 8'h04;
	localparam logic [7:0] TCM_PRESC_ADDR = 8'h08;
	localparam logic [7:0] TCM_PCNT_ADDR = 8'h0C;
	localparam logic [7:0] TCM_MCTRL_ADDR = 8'h10;
	localparam logic [7:0] TCM_EMCTRL_ADDR = 8'h14;
	localparam logic [7:0] TCM_CCTRL_ADDR = 8'h18;
	localparam logic [7:0] TCM_STAT_ADDR = 8'h1C;
	localparam logic [7:0] TCM_MASK_ADDR = 8'h20;
	localparam logic [7:0] TCM_MATCH0_ADDR = 8'h30;
	localparam logic [7:0] TCM_CAP0_ADDR = 8'h40;
	// Control register bits
	localparam int unsigned TCM_CTRL_EN_BIT = 0;
	localparam int unsigned TCM_CTRL_RST_BIT = 1;
	localparam int unsigned TCM_CTRL_EXT_BIT = 2;
	// Match control: per channel bits [3c+0]=irq, [3c+1]=reset, [3c+2]=stop
	localparam int unsigned TCM_MC_IRQ = 0;
	localparam int unsigned TCM_MC_RST = 1;
	localparam int unsigned TCM_MC_STOP = 2;
	// Capture control: per channel [3c+0]=rise, [3c+1]=fall, [3c+2]=irq
	localparam int unsigned TCM_CC_RISE = 0;
	localparam int unsigned TCM_CC_FALL = 1;
	localparam int unsigned TCM_CC_IRQ = 2;
	// External output actions, two bits per channel
	localparam logic [1:0] TCM_EM_NONE = 2'h0;
	localparam logic [1:0] TCM_EM_LOW = 2'h1;
	localparam logic [1:0] TCM_EM_HIGH = 2'h2;
	localparam logic [1:0] TCM_EM_TOGGLE = 2'h3;
	localparam logic [31:0] TCM_RESET_WORD = 32'h0000_0000;
	typedef struct packed {
		logic [31:0] addr;
		logic write;
		logic [31:0] wdata;
	} tcm_req_t;
	typedef struct packed {
		logic [TCM_CH-1:0] cap;
		logic [TCM_CH-1:0] mat;
	} tcm_evt_t;
endpackage

/* File: verilog/tcm_regmem.sv */
// Small register memory for match or capture words with registered read
`timescale 1ns/1ps
module tcm_regmem
	import tcm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [TCM_CH-1:0] we,
	input wire logic [31:0] wdata_a,
	input wire logic [TCM_CH*32-1:0] wdata_v,
	input wire logic [TCM_CH-1:0] sel_v,
	input wire logic [1:0] raddr,
	output logic [31:0] rdata,
	output logic [TCM_CH*32-1:0] words
);
	logic [31:0] mem_q [TCM_CH];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < TCM_CH; i++) begin
				mem_q[i] <= TCM_RESET_WORD;
			end
		end else begin
			for (int i = 0; i < TCM_CH; i++) begin
				if (sel_v[i]) begin
					mem_q[i] <= wdata_v[i*32 +: 32];
				end else if (we[i]) begin
					mem_q[i] <= wdata_a;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata <= TCM_RESET_WORD;
		end else begin
			rdata <= mem_q[raddr];
		end
	end

	always_comb begin
		for (int i = 0; i < TCM_CH; i++) begin
			words[i*32 +: 32] = mem_q[i];
		end
	end
endmodule // tcm_regmem

/* File: verilog/tcm_timer.sv */
// Timer/counter with prescaler, four match and four capture channels, APB slave
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module tcm_timer
	import tcm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_clk,
	input wire logic [TCM_CH-1:0] cap_in,
	output logic [TCM_CH-1:0] match_out,
	output logic irq
);
	////////////////////////////////////////////////////////////////////////////
	// Functions
	function automatic logic sync_edge(input logic cur, input logic prev,
			input logic rise, input logic fall);
		sync_edge = (rise && cur && !prev) || (fall && !cur && prev);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// APB access
	tcm_req_t req;
	logic wr_en, rd_phase_q, is_match, is_cap, reg_err;
	logic [2:0] ctrl_q;
	logic [31:0] count_q, presc_q, pcnt_q, m_rdata, c_rdata, reg_rdata;
	logic [3*TCM_CH-1:0] mctrl_q, cctrl_q;
	logic [2*TCM_CH-1:0] emctrl_q, stat_q, mask_q;
	logic [TCM_CH-1:0] mwe, cwe_unused, cap_evt, mat_evt;
	logic [TCM_CH*32-1:0] m_words, c_words, c_wvec;

	assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
	assign is_match = (req.addr[31:4] == {24'h0, TCM_MATCH0_ADDR[7:4]}) && (req.addr[1:0] == 2'h0);
	assign is_cap = (req.addr[31:4] == {24'h0, TCM_CAP0_ADDR[7:4]}) && (req.addr[1:0] == 2'h0);
	// Reads wait one cycle for the registered memory data
	assign pready = req.write ? 1'b1 : rd_phase_q;
	assign wr_en = psel && penable && req.write;
	assign cwe_unused = '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_phase_q <= 1'b0;
		end else begin
			rd_phase_q <= psel && penable && !req.write && !rd_phase_q;
		end
	end

	always_comb begin
		reg_rdata = TCM_RESET_WORD;
		reg_err = 1'b0;
		if (req.addr == {24'h0, TCM_CTRL_ADDR}) begin
			reg_rdata = {29'h0, ctrl_q};
		end else if (req.addr == {24'h0, TCM_COUNT_ADDR}) begin
			reg_rdata = count_q;
		end else if (req.addr == {24'h0, TCM_PRESC_ADDR}) begin
			reg_rdata = presc_q;
		end else if (req.addr == {24'h0, TCM_PCNT_ADDR}) begin
			reg_rdata = pcnt_q;
		end else if (req.addr == {24'h0, TCM_MCTRL_ADDR}) begin
			reg_rdata = {20'h0, mctrl_q};
		end else if (req.addr == {24'h0, TCM_EMCTRL_ADDR}) begin
			reg_rdata = {20'h0, match_out, emctrl_q};
		end else if (req.addr == {24'h0, TCM_CCTRL_ADDR}) begin
			reg_rdata = {20'h0, cctrl_q};
		end else if (req.addr == {24'h0, TCM_STAT_ADDR}) begin
			reg_rdata = {24'h0, stat_q};
		end else if (req.addr == {24'h0, TCM_MASK_ADDR}) begin
			reg_rdata = {24'h0, mask_q};
		end else if (is_match) begin
			reg_rdata = m_rdata;
		end else if (is_cap) begin
			reg_rdata = c_rdata;
		end else begin
			reg_err = 1'b1;
		end
	end

	assign pslverr = psel && penable && pready && reg_err;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= TCM_RESET_WORD;
		end else if (psel && penable && !req.write && !rd_phase_q) begin
			prdata <= reg_rdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_q <= TCM_RESET_WORD;
			mctrl_q <= '0;
			emctrl_q <= '0;
			cctrl_q <= '0;
			mask_q <= '0;
		end else if (wr_en) begin
			if (req.addr == {24'h0, TCM_PRESC_ADDR}) presc_q <= req.wdata;
			if (req.addr == {24'h0, TCM_MCTRL_ADDR}) mctrl_q <= req.wdata[3*TCM_CH-1:0];
			if (req.addr == {24'h0, TCM_EMCTRL_ADDR}) emctrl_q <= req.wdata[2*TCM_CH-1:0];
			if (req.addr == {24'h0, TCM_CCTRL_ADDR}) cctrl_q <= req.wdata[3*TCM_CH-1:0];
			if (req.addr == {24'h0, TCM_MASK_ADDR}) mask_q <= req.wdata[2*TCM_CH-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= '0;
		end else if (wr_en && req.addr == {24'h0, TCM_CTRL_ADDR}) begin
			ctrl_q <= req.wdata[2:0];
		end else if (|(mat_evt & stop_bits())) begin
			ctrl_q[TCM_CTRL_EN_BIT] <= 1'b0;
		end
	end

	function automatic logic [TCM_CH-1:0] stop_bits();
		for (int i = 0; i < TCM_CH; i++) begin
			stop_bits[i] = mctrl_q[3*i+TCM_MC_STOP];
		end
	endfunction

	always_comb begin
		for (int i = 0; i < TCM_CH; i++) begin
			mwe[i] = wr_en && is_match && (req.addr[3:2] == 2'(i));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Count clock selection and prescaler
	logic ext_s1_q, ext_s2_q, ext_s3_q, tick, pre_hit, cnt_step;
	logic [TCM_CH-1:0] rst_hit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
		end else begin
			ext_s1_q <= ext_clk;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end

	assign tick = ctrl_q[TCM_CTRL_EN_BIT] && !ctrl_q[TCM_CTRL_RST_BIT] &&
		(ctrl_q[TCM_CTRL_EXT_BIT] ? (ext_s2_q && !ext_s3_q) : 1'b1);
	// prescale divide by presc plus one
	assign pre_hit = tick && (pcnt_q >= presc_q);
	assign cnt_step = pre_hit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pcnt_q <= TCM_RESET_WORD;
		end else if (ctrl_q[TCM_CTRL_RST_BIT] || pre_hit) begin
			pcnt_q <= TCM_RESET_WORD;
		end else if (tick) begin
			pcnt_q <= pcnt_q + 32'h0000_0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Match compare and count
	always_comb begin
		for (int i = 0; i < TCM_CH; i++) begin
			mat_evt[i] = cnt_step && (count_q == m_words[i*32 +: 32]);
			rst_hit[i] = mat_evt[i] && mctrl_q[3*i+TCM_MC_RST];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= TCM_RESET_WORD;
		end else if (ctrl_q[TCM_CTRL_RST_BIT]) begin
			count_q <= TCM_RESET_WORD;
		end else if (|rst_hit) begin
			count_q <= TCM_RESET_WORD;
		end else if (cnt_step && !(|(mat_evt & stop_bits()))) begin
			count_q <= count_q + 32'h0000_0001;
		end
	end

	tcm_regmem u_match (
		.pclk(pclk),
		.presetn(presetn),
		.we(mwe),
		.wdata_a(req.wdata),
		.wdata_v('0),
		.sel_v('0),
		.raddr(req.addr[3:2]),
		.rdata(m_rdata),
		.words(m_words)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_out <= '0;
		end else begin
			for (int i = 0; i < TCM_CH; i++) begin
				if (mat_evt[i]) begin
					case (emctrl_q[2*i +: 2])
						TCM_EM_LOW: match_out[i] <= 1'b0;
						TCM_EM_HIGH: match_out[i] <= 1'b1;
						TCM_EM_TOGGLE: match_out[i] <= !match_out[i];
						default: match_out[i] <= match_out[i];
					endcase
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Capture
	logic [TCM_CH-1:0] cap_s1_q, cap_s2_q, cap_s3_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_s1_q <= '0;
			cap_s2_q <= '0;
			cap_s3_q <= '0;
		end else begin
			cap_s1_q <= cap_in;
			cap_s2_q <= cap_s1_q;
			cap_s3_q <= cap_s2_q;
		end
	end

	always_comb begin
		for (int i = 0; i < TCM_CH; i++) begin
			cap_evt[i] = sync_edge(cap_s2_q[i], cap_s3_q[i],
				cctrl_q[3*i+TCM_CC_RISE], cctrl_q[3*i+TCM_CC_FALL]);
			c_wvec[i*32 +: 32] = count_q;
		end
	end

	tcm_regmem u_cap (
		.pclk(pclk),
		.presetn(presetn),
		.we(cwe_unused),
		.wdata_a(req.wdata),
		.wdata_v(c_wvec),
		.sel_v(cap_evt),
		.raddr(req.addr[3:2]),
		.rdata(c_rdata),
		.words(c_words)
	);

	////////////////////////////////////////////////////////////////////////////
	// Interrupt flags
	tcm_evt_t ev;
	always_comb begin
		for (int i = 0; i < TCM_CH; i++) begin
			ev.mat[i] = mat_evt[i] && mctrl_q[3*i+TCM_MC_IRQ];
			ev.cap[i] = cap_evt[i] && cctrl_q[3*i+TCM_CC_IRQ];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= '0;
		end else begin
			stat_q <= (stat_q & ~((wr_en && req.addr == {24'h0, TCM_STAT_ADDR}) ?
				req.wdata[2*TCM_CH-1:0] : '0)) | ev;
		end
	end

	assign irq = |(stat_q & mask_q);

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	a_prescale_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(tick && pcnt_q < presc_q) |=> $stable(count_q))
		else $error("count moved before prescaler limit");
	a_stop_halts: assert property (@(posedge pclk) disable iff (!presetn)
		(|(mat_evt & stop_bits()) && !wr_en) |=> !ctrl_q[TCM_CTRL_EN_BIT])
		else $error("stop match did not halt");
	a_reset_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(|rst_hit) |=> count_q == 32'h0)
		else $error("reset match did not clear count");
	a_match_event: assert property (@(posedge pclk) disable iff (!presetn)
		(cnt_step && count_q == m_words[31:0] && mctrl_q[TCM_MC_IRQ]) |=> stat_q[0])
		else $error("match on channel zero not flagged");
	a_cont_count: assert property (@(posedge pclk) disable iff (!presetn)
		(cnt_step && !(|mat_evt) && !ctrl_q[TCM_CTRL_RST_BIT]) |=>
		count_q == $past(count_q) + 32'h1)
		else $error("count failed to advance");
	a_toggle_out: assert property (@(posedge pclk) disable iff (!presetn)
		(mat_evt[0] && emctrl_q[1:0] == TCM_EM_TOGGLE) |=>
		match_out[0] != $past(match_out[0]))
		else $error("output did not toggle");
	a_capture_copy: assert property (@(posedge pclk) disable iff (!presetn)
		cap_evt[0] |=> c_words[31:0] == $past(count_q))
		else $error("capture value wrong");
	a_capture_irq: assert property (@(posedge pclk) disable iff (!presetn)
		(cap_evt[1] && cctrl_q[3+TCM_CC_IRQ]) |=> stat_q[TCM_CH+1])
		else $error("capture flag not set");
	a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && req.addr == {24'h0, TCM_STAT_ADDR} && req.wdata[0] && !ev.mat[0]) |=> !stat_q[0])
		else $error("status flag not cleared by write of one");
	a_edge_sel: assert property (@(posedge pclk) disable iff (!presetn)
		(cap_evt[0] && !cctrl_q[TCM_CC_FALL]) |-> cap_s2_q[0])
		else $error("falling edge captured while disabled");
	a_ext_source: assert property (@(posedge pclk) disable iff (!presetn)
		(ctrl_q[TCM_CTRL_EXT_BIT] && !(ext_s2_q && !ext_s3_q)) |-> !tick)
		else $error("external mode ticked without edge");
	c_match_reset: cover property (@(posedge pclk) disable iff (!presetn) |rst_hit);
	c_capture: cover property (@(posedge pclk) disable iff (!presetn) |cap_evt);
	c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule // tcm_timer

/* File: verif/tcm_pin_model.sv */
// Pin-side model: capture inputs and external count clock
`timescale 1ns/1ps
module tcm_pin_model
	import tcm_pkg::*;
(
	input wire logic pclk,
	output logic ext_clk,
	output logic [TCM_CH-1:0] cap_in,
	input wire logic [TCM_CH-1:0] match_out
);
	initial begin
		ext_clk = 1'b0;
		cap_in = '0;
	end
	// New level on the capture pins, held long enough for the synchroniser
	task automatic set_cap(input logic [TCM_CH-1:0] v);
		@(posedge pclk);
		cap_in <= v;
		repeat (6) @(posedge pclk);
	endtask
	// Slow external clock pulses, idle low between them
	task automatic pulse_ext(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			ext_clk <= 1'b1;
			repeat (3) @(posedge pclk);
			ext_clk <= 1'b0;
			repeat (3) @(posedge pclk);
		end
	endtask
endmodule // tcm_pin_model

/* File: verif/tb_tcm_timer.sv */
// Self-checking bench for the timer/counter with capture and match
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_tcm_timer import tcm_pkg::*;;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	tcm_req_t req = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic ext_clk;
	logic [TCM_CH-1:0] cap_in;
	logic [TCM_CH-1:0] match_out;
	logic irq;
	int failures = 0;
	int checked = 0;
	logic [31:0] v;

	always #2 pclk = ~pclk;

	tcm_timer u_tcm_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(req.write), .paddr(req.addr), .pwdata(req.wdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_clk(ext_clk), .cap_in(cap_in),
		.match_out(match_out), .irq(irq));
	tcm_pin_model u_tcm_pin_model (.pclk(pclk), .ext_clk(ext_clk), .cap_in(cap_in),
		.match_out(match_out));

	////////////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r, output logic err);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		req <= '{addr: {24'h0, a}, write: w, wdata: d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) failures++;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(a, 1'b1, d, r, e);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(a, 1'b0, 32'h0, r, e);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		rd(a, r);
		`CHK(r, x)
	endtask
	// Clear the count, then start with the given control word
	task automatic run(input logic [31:0] c);
		wr(TCM_CTRL_ADDR, 32'h2);
		wr(TCM_CTRL_ADDR, c);
	endtask
	task automatic test_done();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [31:0] r;
		logic e;
		rdc(TCM_CTRL_ADDR, TCM_RESET_WORD);
		rdc(TCM_STAT_ADDR, TCM_RESET_WORD);
		rdc(TCM_MATCH0_ADDR, TCM_RESET_WORD);
		`CHK(match_out, 4'h0)
		`CHK(irq, 1'b0)
		apb(8'h2C, 1'b0, 32'h0, r, e);
		`CHK(e, 1'b1)
		$display("test reset done");
	endtask
	// prescaled count up to a stop match
	task automatic t_presc();
		wr(TCM_PRESC_ADDR, 32'h3);
		wr(TCM_MATCH0_ADDR, 32'h5);
		wr(TCM_MCTRL_ADDR, 32'h5);
		run(32'h1);
		repeat (8) @(posedge pclk);
		rd(TCM_COUNT_ADDR, v);
		`CHK(v > 32'h0 && v < 32'h5, 1'b1)
		repeat (30) @(posedge pclk);
		rdc(TCM_COUNT_ADDR, 32'h5);
		rdc(TCM_CTRL_ADDR, 32'h0);
		rdc(TCM_STAT_ADDR, 32'h1);
		wr(TCM_MASK_ADDR, 32'h1);
		`CHK(irq, 1'b1)
		wr(TCM_STAT_ADDR, 32'h1);
		`CHK(irq, 1'b0)
		rdc(TCM_STAT_ADDR, 32'h0);
		$display("test prescale stop done");
	endtask
	task automatic t_out();
		logic [1:0] act [5];
		logic ex [5];
		act = '{TCM_EM_HIGH, TCM_EM_NONE, TCM_EM_LOW, TCM_EM_TOGGLE, TCM_EM_TOGGLE};
		ex = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
		wr(TCM_PRESC_ADDR, 32'h0);
		for (int i = 0; i < 5; i++) begin
			wr(TCM_EMCTRL_ADDR, {30'h0, act[i]});
			run(32'h1);
			repeat (12) @(posedge pclk);
			`CHK(match_out[0], ex[i])
			rd(TCM_EMCTRL_ADDR, v);
			`CHK(v[8], ex[i])
		end
		$display("test output actions done");
	endtask
	// continuous match with interrupt, reset match
	task automatic t_cont();
		wr(TCM_MATCH0_ADDR, 32'h2);
		wr(TCM_MATCH0_ADDR + 8'h04, 32'h7);
		wr(TCM_MCTRL_ADDR, 32'h11);
		wr(TCM_STAT_ADDR, 32'hFF);
		wr(TCM_MASK_ADDR, 32'h1);
		run(32'h1);
		repeat (20) @(posedge pclk);
		rd(TCM_COUNT_ADDR, v);
		`CHK(v <= 32'h7, 1'b1)
		rdc(TCM_CTRL_ADDR, 32'h1);
		rdc(TCM_STAT_ADDR, 32'h1);
		`CHK(irq, 1'b1)
		wr(TCM_MASK_ADDR, 32'h0);
		`CHK(irq, 1'b0)
		wr(TCM_CTRL_ADDR, 32'h0);
		$display("test continuous reset done");
	endtask
	task automatic t_cap();
		wr(TCM_MCTRL_ADDR, 32'h4);
		run(32'h1);
		repeat (8) @(posedge pclk);
		rdc(TCM_COUNT_ADDR, 32'h2);
		wr(TCM_CCTRL_ADDR, 32'h9F5);
		wr(TCM_STAT_ADDR, 32'hFF);
		u_tcm_pin_model.set_cap(4'hF);
		rdc(TCM_STAT_ADDR, 32'h50);
		wr(TCM_STAT_ADDR, 32'hFF);
		u_tcm_pin_model.set_cap(4'h0);
		rdc(TCM_STAT_ADDR, 32'h60);
		wr(TCM_MASK_ADDR, 32'hF0);
		`CHK(irq, 1'b1)
		rdc(TCM_CAP0_ADDR, 32'h2);
		wr(TCM_CAP0_ADDR, 32'h123);
		rdc(TCM_CAP0_ADDR, 32'h2);
		rdc(TCM_CAP0_ADDR + 8'h04, 32'h2);
		rdc(TCM_CAP0_ADDR + 8'h0C, 32'h0);
		wr(TCM_STAT_ADDR, 32'hFF);
		`CHK(irq, 1'b0)
		wr(TCM_MASK_ADDR, 32'h0);
		$display("test capture done");
	endtask
	task automatic t_ext();
		wr(TCM_MCTRL_ADDR, 32'h0);
		run(32'h5);
		u_tcm_pin_model.pulse_ext(6);
		repeat (4) @(posedge pclk);
		rdc(TCM_COUNT_ADDR, 32'h6);
		$display("test external clock done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_presc();
		t_out();
		t_cont();
		t_cap();
		t_ext();
		test_done();
	end
	initial begin
		#40000;
		failures++;
		test_done();
	end
endmodule // tb_tcm_timer
